/* include/dts_pkg.sv */
// constants, types and the delay lookup for the two-axis torque-off delay logic
// assumes a single 20 MHz reference clock shared by every module of the block
package dts_pkg;

    // clock rate in kHz, so that a time in ms times this gives cycles
    localparam int CLK_KHZ = 20000;

    // selectable shut-off delays in ms
    localparam int DLY_1P4_MS = 1400;
    localparam int DLY_2P8_MS = 2800;
    localparam int DLY_5P6_MS = 5600;
    localparam int DLY_9P8_MS = 9800;
    localparam int DLY_30P8_MS = 30800;
    // how long two signals that should agree may disagree before a fault
    localparam int DISC_MS = 10;

    localparam int CNT_W = 30;
    typedef logic [CNT_W-1:0] dts_cnt_type;

    // cycle counts derived from the times above
    localparam dts_cnt_type DLY_CNT_1P4 = dts_cnt_type'(DLY_1P4_MS * CLK_KHZ);
    localparam dts_cnt_type DLY_CNT_2P8 = dts_cnt_type'(DLY_2P8_MS * CLK_KHZ);
    localparam dts_cnt_type DLY_CNT_5P6 = dts_cnt_type'(DLY_5P6_MS * CLK_KHZ);
    localparam dts_cnt_type DLY_CNT_9P8 = dts_cnt_type'(DLY_9P8_MS * CLK_KHZ);
    localparam dts_cnt_type DLY_CNT_30P8 = dts_cnt_type'(DLY_30P8_MS * CLK_KHZ);
    localparam int DISC_CNT = DISC_MS * CLK_KHZ;

    // per-axis state, gray along run -> delay -> off
    typedef enum logic [1:0] {
        AX_RUN = 2'b00,
        AX_DELAY = 2'b01,
        AX_OFF = 2'b11
    } dts_axis_state_type;

    // register byte offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h4;
    localparam logic [3:0] REG_STATE = 4'h8;

    // status and mask layout: two bits each, bit 0 axis A, bit 1 axis B
    localparam int EV_W = 6;
    localparam int EV_OFF = 0;
    localparam int EV_REL = 2;
    localparam int EV_FLT = 4;
    localparam logic [EV_W-1:0] MASK_RST = 6'h00;
    localparam logic [EV_W-1:0] STATUS_RST = 6'h00;

    // state register field positions
    localparam int ST_OFF = 0;
    localparam int ST_FLT = 2;
    localparam int ST_MATCH = 4;
    localparam int ST_SEL1 = 8;
    localparam int ST_SEL2 = 12;
    localparam int ST_SWERR = 16;
    localparam int ST_FBERR = 18;

    localparam logic [3:0] SEL_RST = 4'h0;

    // selector code -> {axis A index, axis B index}; 0:0 s 1:1.4 2:2.8 3:5.6 4:9.8 5:30.8
    function automatic logic [5:0] dly_code(input logic [3:0] code);
        unique case (code)
            4'h0: dly_code = {3'h0, 3'h0};
            4'h1: dly_code = {3'h0, 3'h1};
            4'h2: dly_code = {3'h0, 3'h2};
            4'h3: dly_code = {3'h0, 3'h4};
            4'h4: dly_code = {3'h0, 3'h5};
            4'h5: dly_code = {3'h1, 3'h2};
            4'h6: dly_code = {3'h1, 3'h4};
            4'h7: dly_code = {3'h1, 3'h5};
            4'h8: dly_code = {3'h2, 3'h2};
            4'h9: dly_code = {3'h2, 3'h4};
            4'hA: dly_code = {3'h2, 3'h5};
            4'hB: dly_code = {3'h3, 3'h4};
            4'hC: dly_code = {3'h3, 3'h5};
            4'hD: dly_code = {3'h4, 3'h4};
            4'hE: dly_code = {3'h4, 3'h5};
            4'hF: dly_code = {3'h5, 3'h5};
        endcase
    endfunction

endpackage

/* sim/dts_partner.sv */
// drive-side model: redundant shut-off contacts and torque-off feedback
// assumes the bench clock; feedback trails the outputs by P_LAG cycles
`timescale 1ns/1ns
module dts_partner #(
    parameter int P_LAG = 2
) (
    input wire logic i_ref_clk,
    input wire logic [1:0] i_req,
    input wire logic [1:0] i_out_one,
    input wire logic [1:0] i_out_two,
    output logic [1:0] o_sd_one,
    output logic [1:0] o_sd_two,
    output logic [1:0] o_fb
);
    logic [1:0] lag_ff [P_LAG];
    // both contacts carry the same request, open (0) to stop
    assign o_sd_one = ~i_req;
    assign o_sd_two = ~i_req;
    // a real drive reports off late, so feedback lags the outputs
    always_ff @(posedge i_ref_clk) begin
        lag_ff[0] <= i_out_one & i_out_two;
        for (int i = 1; i < P_LAG; i++) begin
            lag_ff[i] <= lag_ff[i-1];
        end
    end
    assign o_fb = lag_ff[P_LAG-1];
endmodule

/* sim/testbench.sv */
// self-checking bench: delay table, indicators, restart, fault hold, registers
// assumes shortened delay counts and the drive model in dts_partner
`timescale 1ns/1ns
module testbench;
    import dts_pkg::*;
    localparam int CN[6] = '{0, 5, 10, 20, 40, 80};
    localparam logic [63:0] IA = 64'h5443322211100000;
    localparam logic [63:0] IB = 64'h5545454254254210;
    // discrepancy filter length, short enough for a quick fault test
    localparam int DC = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [1:0] req = 2'h0;
    logic [1:0] rs = 2'h0;
    logic [3:0] s1 = 4'h0;
    logic [3:0] s2 = 4'h0;
    logic [3:0] ad = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] q, rdat;
    logic [1:0] sd1, sd2, fb, o1, o2, lr, ls1, ls2, lto, lo1, lo2, lm, lf;
    logic pw, wq, irq;
    int fails = 0;
    int checks = 0;
    int na, nb;
    // 20 MHz reference
    initial begin
        forever #25 clk = ~clk;
    end
    dts_partner u_drv (.i_ref_clk(clk), .i_req(req), .i_out_one(o1), .i_out_two(o2),
        .o_sd_one(sd1), .o_sd_two(sd2), .o_fb(fb));
    dts_top #(.P_CNT_1P4(dts_cnt_type'(CN[1])), .P_CNT_2P8(dts_cnt_type'(CN[2])),
        .P_CNT_5P6(dts_cnt_type'(CN[3])), .P_CNT_9P8(dts_cnt_type'(CN[4])),
        .P_CNT_30P8(dts_cnt_type'(CN[5])), .P_DISC_CNT(DC)) u_dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_shutoff_input_one(sd1),
        .i_shutoff_input_two(sd2), .i_safety_restart_input(rs), .i_torque_off_feedback(fb),
        .i_delay_selector_one(s1), .i_delay_selector_two(s2), .o_torque_off_output_one(o1),
        .o_torque_off_output_two(o2), .o_led_restart(lr), .o_led_shutoff_one(ls1),
        .o_led_shutoff_two(ls2), .o_led_torque_off(lto), .o_led_output_one(lo1),
        .o_led_output_two(lo2), .o_led_sel_match(lm), .o_led_fault(lf), .o_led_power(pw),
        .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .o_irq(irq));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one access; waitrequest is read mid-cycle so the edge decision is race free
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        logic busy;
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(negedge clk);
            busy = wq;
            @(posedge clk);
        end while (busy);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // power cycle; selectors then wander to show they were latched
    task automatic boot(input logic [3:0] a, input logic [3:0] b, input logic [1:0] m);
        s1 <= a;
        s2 <= b;
        rst <= 1'b1;
        req <= 2'h0;
        rs <= 2'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s1 <= 4'($urandom);
        s2 <= 4'($urandom);
        @(posedge clk);
        @(negedge clk);
        chk("power", 32'h1, pw);
        chk("sel_match", m, lm);
        chk("out_one", 32'h0, o1);
        @(posedge clk);
    endtask
    // restart closed for a random spell, then opened; e is the outputs expected after
    task automatic restart(input logic [1:0] e);
        rs <= 2'h3;
        repeat ($urandom_range(2, 5)) @(posedge clk);
        @(negedge clk);
        chk("led_restart", 32'h3, lr);
        @(posedge clk);
        rs <= 2'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("out_one", e, o1);
        chk("out_two", e, o2);
        chk("led_off", {~e}, lto);
        chk("led_restart", 32'h0, lr);
        @(posedge clk);
    endtask
    // lane-0-off mask write ignored, state readback, interrupt, clear, unmapped place
    task automatic regs();
        be <= 4'h0;
        bus(1'b1, 4'h4, 32'h3);
        be <= 4'hF;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("irq_masked", 32'h0, irq);
        bus(1'b0, 4'h8, 32'h0);
        chk("state", 32'h5513, q);
        bus(1'b1, 4'hC, 32'hFFFFFFFF);
        bus(1'b0, 4'hC, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, 4'h4, 32'h3);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("irq_on", 32'h1, irq);
        bus(1'b1, 4'h0, 32'h3F);
        bus(1'b0, 4'h0, 32'h0);
        chk("status", 32'h0, q);
        @(negedge clk);
        chk("irq_off", 32'h0, irq);
        @(posedge clk);
    endtask
    // every selector code, then a selector mismatch
    initial begin
        void'($urandom(32'h0D65));
        for (int c = 0; c < 16; c++) begin
            boot(4'(c), 4'(c), 2'h3);
            restart(2'h3);
            req <= 2'h3;
            na = 0;
            nb = 0;
            for (int n = 1; n < 200 && (na == 0 || nb == 0); n++) begin
                @(negedge clk);
                if (na == 0 && o1[0] === 1'b0) na = n;
                if (nb == 0 && o1[1] === 1'b0) nb = n;
                chk("out_pair", o1, o2);
                @(posedge clk);
            end
            chk("delay_a", CN[IA[c*4+:4]] + 2, na);
            chk("delay_b", CN[IB[c*4+:4]] + 2, nb);
            @(negedge clk);
            chk("led_sd1", 32'h3, ls1);
            chk("led_sd2", 32'h3, ls2);
            chk("led_out", 32'hF, {lo1, lo2});
            chk("fault", 32'h0, lf);
            @(posedge clk);
            if (c == 5) regs();
            $display("code %0d done", c);
        end
        boot(4'h3, 4'h5, 2'h0);
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk("fault", 32'h3, lf);
        @(posedge clk);
        restart(2'h0);
        $display("selector mismatch done");
        finish_test();
    end
    // hang guard, far beyond the roughly one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule

/* src/dts_axis.sv */
// one axis: run, timed delay after a shut-off request, torque-off, restart on release edge
// assumes request, restart and fault are synchronous and already combined by the caller
`timescale 1ns/1ns
module dts_axis (
    input logic i_ref_clk,
    input logic i_sys_rst,
    input logic i_off_req,
    input logic i_restart,
    input logic i_fault,
    input dts_pkg::dts_cnt_type i_delay_cnt,
    output logic o_torque_off,
    output logic o_enter_pulse,
    output logic o_release_pulse
);
    import dts_pkg::*;

    dts_axis_state_type state_ff, nxt_state;
    dts_cnt_type cnt_ff, nxt_cnt, age_ff;
    logic restart_ff, off_ff, enter_ff, release_ff;

    // release only on the closed-to-open edge, so a stuck contact cannot restart
    wire logic restart_fall = restart_ff & ~i_restart;
    wire logic delay_done = (cnt_ff == i_delay_cnt - dts_cnt_type'(1));
    wire logic zero_delay = (i_delay_cnt == '0);

    // next state
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            AX_RUN: begin
                if (i_fault) begin
                    nxt_state = AX_OFF;
                end else if (i_off_req) begin
                    nxt_cnt = '0;
                    nxt_state = zero_delay ? AX_OFF : AX_DELAY;
                end
            end
            AX_DELAY: begin
                nxt_cnt = cnt_ff + dts_cnt_type'(1);
                // a started stop runs to completion even if the request goes away
                if (i_fault || delay_done) begin
                    nxt_state = AX_OFF;
                end
            end
            AX_OFF: begin
                if (restart_fall && !i_off_req && !i_fault) begin
                    nxt_state = AX_RUN;
                end
            end
            default: nxt_state = AX_OFF;
        endcase
    end

    // power-up lands in torque-off: the drive must be released deliberately
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_ff <= AX_OFF;
            cnt_ff <= '0;
            restart_ff <= 1'b0;
            off_ff <= 1'b1;
            enter_ff <= 1'b0;
            release_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            restart_ff <= i_restart;
            off_ff <= (nxt_state == AX_OFF);
            enter_ff <= (nxt_state == AX_OFF) && (state_ff != AX_OFF);
            release_ff <= (state_ff == AX_OFF) && (nxt_state != AX_OFF);
        end
    end

    assign o_torque_off = off_ff;
    assign o_enter_pulse = enter_ff;
    assign o_release_pulse = release_ff;

    // cycles spent since leaving run, for checking only
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || state_ff == AX_RUN) begin
            age_ff <= '0;
        end else begin
            age_ff <= age_ff + dts_cnt_type'(1);
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    property p_delay_exact;
        ($rose(off_ff) && $past(state_ff) == AX_DELAY && !$past(i_fault))
            |-> (age_ff == i_delay_cnt);
    endproperty
    a_delay_exact: assert property (p_delay_exact)
        else $error("torque-off came at the wrong delay");

    sequence s_restart_fell;
        $past(restart_ff) && !$past(i_restart);
    endsequence
    property p_release_on_fall;
        $fell(off_ff) |-> s_restart_fell;
    endproperty
    a_release_on_fall: assert property (p_release_on_fall)
        else $error("axis released without a restart opening edge");

    property p_fault_forces_off;
        i_fault |=> off_ff;
    endproperty
    a_fault_forces_off: assert property (p_fault_forces_off)
        else $error("axis not in torque-off while faulted");
endmodule

/* src/dts_persist.sv */
// persistence filter: flags a condition that has held without a break for a set count
// assumes the condition is synchronous to the reference clock
`timescale 1ns/1ns
module dts_persist #(
    parameter int P_LIMIT = 200000
) (
    input logic i_ref_clk,
    input logic i_sys_rst,
    input logic i_cond,
    output logic o_hit
);
    import dts_pkg::*;

    localparam int W = $clog2(P_LIMIT + 1);
    localparam logic [W-1:0] LIMIT = W'(P_LIMIT);

    logic [W-1:0] cnt_ff;

    // saturating count; any break in the condition starts it over
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || !i_cond) begin
            cnt_ff <= '0;
        end else if (cnt_ff != LIMIT) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign o_hit = (cnt_ff == LIMIT);
endmodule

/* src/dts_top.sv */
// two-axis torque-off delay and monitor logic with an Avalon-MM register slave
// assumes all contact inputs are synchronous to i_ref_clk (debounced outside)
// contact inputs: 1 = contact closed; torque-off outputs: 1 = contact closed (run)
// What this block does
// - torque-off after selected axis delay elapses, or at once on fault
// - both selectors equal; common code picks delays
// - codes 0..4: A zero, B per table
// - codes 5..A: A 1.4/2.8 s, B per table
// - codes B..F: A 5.6/9.8/30.8 s
// - selectors captured at power-up only
// - agreement indicator lit when selectors match
// - restart indicator follows restart contact closed
// - shut-off indicators lit while contact open
// - torque-off indicators lit in torque-off state
// - fault indicator dark until fault detected
// - indicator set per axis plus power
// - either shut-off input open requests torque-off
// - release only on restart closed-to-open edge
// - both torque-off outputs of axis identical
// - fault on selector, switch or feedback error
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
module dts_top #(
    parameter dts_pkg::dts_cnt_type P_CNT_1P4 = dts_pkg::DLY_CNT_1P4,
    parameter dts_pkg::dts_cnt_type P_CNT_2P8 = dts_pkg::DLY_CNT_2P8,
    parameter dts_pkg::dts_cnt_type P_CNT_5P6 = dts_pkg::DLY_CNT_5P6,
    parameter dts_pkg::dts_cnt_type P_CNT_9P8 = dts_pkg::DLY_CNT_9P8,
    parameter dts_pkg::dts_cnt_type P_CNT_30P8 = dts_pkg::DLY_CNT_30P8,
    parameter int P_DISC_CNT = dts_pkg::DISC_CNT
) (
    input logic i_ref_clk,
    input logic i_sys_rst,
    input logic [1:0] i_shutoff_input_one,
    input logic [1:0] i_shutoff_input_two,
    input logic [1:0] i_safety_restart_input,
    input logic [1:0] i_torque_off_feedback,
    input logic [3:0] i_delay_selector_one,
    input logic [3:0] i_delay_selector_two,
    output logic [1:0] o_torque_off_output_one,
    output logic [1:0] o_torque_off_output_two,
    output logic [1:0] o_led_restart,
    output logic [1:0] o_led_shutoff_one,
    output logic [1:0] o_led_shutoff_two,
    output logic [1:0] o_led_torque_off,
    output logic [1:0] o_led_output_one,
    output logic [1:0] o_led_output_two,
    output logic [1:0] o_led_sel_match,
    output logic [1:0] o_led_fault,
    output logic o_led_power,
    input logic [3:0] i_avs_address,
    input logic i_avs_read,
    input logic i_avs_write,
    input logic [31:0] i_avs_writedata,
    input logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq
);
    import dts_pkg::*;

    logic [3:0] sel1_ff, sel2_ff;
    logic cap_done_ff;
    logic [1:0] flt_ff;
    logic [1:0] off;
    logic [1:0] enter_p, release_p;
    logic [1:0] sw_err, fb_err;
    logic [1:0] led_rst_ff, led_shutoff_input_one_ff, led_shutoff_input_two_ff;
    logic power_ff;
    logic [EV_W-1:0] status_ff, nxt_status, mask_ff, ev;
    logic ack_ff, irq_ff;
    logic [31:0] rdata_ff, state_word;
    dts_cnt_type dly_tab [6];
    dts_cnt_type axis_dly [2];

    // selectors are latched once after power-up; later turns are ignored
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            sel1_ff <= SEL_RST;
            sel2_ff <= SEL_RST;
            cap_done_ff <= 1'b0;
        end else if (!cap_done_ff) begin
            sel1_ff <= i_delay_selector_one;
            sel2_ff <= i_delay_selector_two;
            cap_done_ff <= 1'b1;
        end
    end

    // selector agreement and delay lookup from the common code
    wire logic sel_match = cap_done_ff && (sel1_ff == sel2_ff);
    wire logic [5:0] dly_idx = dly_code(sel1_ff);
    assign dly_tab[0] = '0;
    assign dly_tab[1] = P_CNT_1P4;
    assign dly_tab[2] = P_CNT_2P8;
    assign dly_tab[3] = P_CNT_5P6;
    assign dly_tab[4] = P_CNT_9P8;
    assign dly_tab[5] = P_CNT_30P8;
    assign axis_dly[0] = dly_tab[dly_idx[5:3]];
    assign axis_dly[1] = dly_tab[dly_idx[2:0]];

    // per-axis sequencing and discrepancy filters
    for (genvar g = 0; g < 2; g++) begin : g_axis
        // either contact open is a request; a broken wire therefore stops the axis
        wire logic off_req = ~i_shutoff_input_one[g] | ~i_shutoff_input_two[g];
        // feedback closed means the drive is running, so it must mirror our state
        wire logic fb_bad = (i_torque_off_feedback[g] == off[g]);
        wire logic sw_bad = (i_shutoff_input_one[g] != i_shutoff_input_two[g]);

        dts_axis u_axis (
            .i_ref_clk(i_ref_clk),
            .i_sys_rst(i_sys_rst),
            .i_off_req(off_req),
            .i_restart(i_safety_restart_input[g]),
            .i_fault(flt_ff[g]),
            .i_delay_cnt(axis_dly[g]),
            .o_torque_off(off[g]),
            .o_enter_pulse(enter_p[g]),
            .o_release_pulse(release_p[g])
        );

        dts_persist #(.P_LIMIT(P_DISC_CNT)) u_sw_chk (
            .i_ref_clk(i_ref_clk),
            .i_sys_rst(i_sys_rst),
            .i_cond(sw_bad),
            .o_hit(sw_err[g])
        );

        dts_persist #(.P_LIMIT(P_DISC_CNT)) u_fb_chk (
            .i_ref_clk(i_ref_clk),
            .i_sys_rst(i_sys_rst),
            .i_cond(fb_bad),
            .o_hit(fb_err[g])
        );
    end

    // fault latches until power is cycled; a selector mismatch faults both axes
    wire logic [1:0] flt_cause = sw_err | fb_err | {2{cap_done_ff && !sel_match}};
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            flt_ff <= 2'h0;
        end else begin
            flt_ff <= flt_ff | flt_cause;
        end
    end

    // input monitor indicators, one cycle behind the contacts
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            led_rst_ff <= 2'h0;
            led_shutoff_input_one_ff <= 2'h0;
            led_shutoff_input_two_ff <= 2'h0;
            power_ff <= 1'b0;
        end else begin
            led_rst_ff <= i_safety_restart_input;
            led_shutoff_input_one_ff <= ~i_shutoff_input_one;
            led_shutoff_input_two_ff <= ~i_shutoff_input_two;
            power_ff <= 1'b1;
        end
    end

    // outputs: both channels of an axis come from the one state flop
    assign o_torque_off_output_one = ~off;
    assign o_torque_off_output_two = ~off;
    assign o_led_torque_off = off;
    assign o_led_output_one = off;
    assign o_led_output_two = off;
    assign o_led_restart = led_rst_ff;
    assign o_led_shutoff_one = led_shutoff_input_one_ff;
    assign o_led_shutoff_two = led_shutoff_input_two_ff;
    assign o_led_sel_match = {2{sel_match}};
    assign o_led_fault = flt_ff;
    assign o_led_power = power_ff;

    // bus decode: every access takes exactly one wait cycle
    wire logic req = i_avs_read | i_avs_write;
    wire logic done = req & ack_ff;
    wire logic wr_lane0 = done & i_avs_write & i_avs_byteenable[0];
    wire logic wr_status = wr_lane0 & (i_avs_address == REG_STATUS);
    wire logic wr_mask = wr_lane0 & (i_avs_address == REG_MASK);
    assign o_avs_waitrequest = req & ~ack_ff;

    // readable state word
    always_comb begin
        state_word = 32'h0000_0000;
        state_word[ST_OFF +: 2] = off;
        state_word[ST_FLT +: 2] = flt_ff;
        state_word[ST_MATCH] = sel_match;
        state_word[ST_SEL1 +: 4] = sel1_ff;
        state_word[ST_SEL2 +: 4] = sel2_ff;
        state_word[ST_SWERR +: 2] = sw_err;
        state_word[ST_FBERR +: 2] = fb_err;
    end

    wire logic [31:0] rd_mux =
        (i_avs_address == REG_STATUS) ? 32'(status_ff) :
        (i_avs_address == REG_MASK) ? 32'(mask_ff) :
        (i_avs_address == REG_STATE) ? state_word : 32'h0000_0000;

    // events; a set in the same cycle as a write-one clear wins
    always_comb begin
        ev = '0;
        ev[EV_OFF +: 2] = enter_p;
        ev[EV_REL +: 2] = release_p;
        ev[EV_FLT +: 2] = flt_cause & ~flt_ff;
        nxt_status = status_ff & ~(wr_status ? i_avs_writedata[EV_W-1:0] : '0);
        nxt_status = nxt_status | ev;
    end

    // register file and bus handshake
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            status_ff <= STATUS_RST;
            mask_ff <= MASK_RST;
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            mask_ff <= wr_mask ? i_avs_writedata[EV_W-1:0] : mask_ff;
            ack_ff <= req & ~ack_ff;
            rdata_ff <= (i_avs_read & ~ack_ff) ? rd_mux : rdata_ff;
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    assign o_avs_readdata = rdata_ff;
    assign o_irq = irq_ff;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    property p_sel_frozen;
        cap_done_ff |=> ($stable(sel1_ff) && $stable(sel2_ff));
    endproperty
    a_sel_frozen: assert property (p_sel_frozen)
        else $error("captured selector code changed while powered");

    property p_match_led;
        cap_done_ff |-> (o_led_sel_match[0] == (sel1_ff == sel2_ff));
    endproperty
    a_match_led: assert property (p_match_led)
        else $error("agreement indicator disagrees with selectors");

    property p_restart_led;
        !$past(i_sys_rst) |-> (o_led_restart == $past(i_safety_restart_input));
    endproperty
    a_restart_led: assert property (p_restart_led)
        else $error("restart indicator does not follow contact");

    property p_shutoff_led;
        !$past(i_sys_rst) |-> (o_led_shutoff_one == ~$past(i_shutoff_input_one))
            && (o_led_shutoff_two == ~$past(i_shutoff_input_two));
    endproperty
    a_shutoff_led: assert property (p_shutoff_led)
        else $error("shut-off indicator does not follow contact");

    property p_outputs_pair;
        (o_torque_off_output_one == o_torque_off_output_two)
            && (o_led_torque_off == ~o_torque_off_output_one);
    endproperty
    a_outputs_pair: assert property (p_outputs_pair)
        else $error("torque-off channels of an axis differ");

    sequence s_sel_mismatch;
        cap_done_ff && (sel1_ff != sel2_ff);
    endsequence
    property p_mismatch_fault;
        s_sel_mismatch |=> (o_led_fault == 2'h3);
    endproperty
    a_mismatch_fault: assert property (p_mismatch_fault)
        else $error("selector mismatch did not raise fault");

    property p_fault_sticky;
        1'b1 |=> ((o_led_fault & $past(o_led_fault)) == $past(o_led_fault));
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault indicator cleared without power cycle");

    property p_power_led;
        !$past(i_sys_rst) |-> o_led_power;
    endproperty
    a_power_led: assert property (p_power_led)
        else $error("power indicator dark while running");

    property p_code_f;
        (cap_done_ff && sel1_ff == 4'hF)
            |-> (axis_dly[0] == P_CNT_30P8) && (axis_dly[1] == P_CNT_30P8);
    endproperty
    a_code_f: assert property (p_code_f)
        else $error("code F did not select longest delay");

    property p_code_5;
        (cap_done_ff && sel1_ff == 4'h5)
            |-> (axis_dly[0] == P_CNT_1P4) && (axis_dly[1] == P_CNT_2P8);
    endproperty
    a_code_5: assert property (p_code_5)
        else $error("code 5 delays wrong");

    property p_code_0;
        (cap_done_ff && sel1_ff == 4'h0) |-> (axis_dly[0] == '0) && (axis_dly[1] == '0);
    endproperty
    a_code_0: assert property (p_code_0)
        else $error("code 0 is not zero delay");

    property p_bus_one_wait;
        (req && o_avs_waitrequest) |=> !o_avs_waitrequest;
    endproperty
    a_bus_one_wait: assert property (p_bus_one_wait)
        else $error("bus answer later than one wait cycle");
endmodule
